/* File: hw/thd_cfg.svh */
// register offsets, field positions and reset values of the hamming decoder
`ifndef THD_CFG_SVH
`define THD_CFG_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define THD_OFF_HIGH    5'h00
`define THD_OFF_MID     5'h04
`define THD_OFF_LOW     5'h08
`define THD_OFF_CTRL    5'h0c
`define THD_OFF_RESULT  5'h10
`define THD_OFF_STATUS  5'h14
`define THD_OFF_MASK    5'h18

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define THD_CTRL_MODE_BIT 0
`define THD_STA_DONE_BIT  0
`define THD_STA_ERR_BIT   1
`define THD_ERR24_BIT     23
`define THD_ERR8_BIT      4

// ----------------------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------------------
`define THD_BYTE_RST      8'h00
`define THD_FLAG_RST      2'h0
`define THD_LAST_POS      5'h17

`endif

/* File: hw/thd_pkg.sv */
// shared types of the hamming decoder
package thd_pkg;
    // one three-byte code word
    typedef logic [23:0] thd_word_t;
    // check selection
    typedef enum logic {THD_MODE_BYTE = 1'h0, THD_MODE_GROUP = 1'h1} thd_mode_t;
    // bus write/read responses
    typedef enum logic [1:0] {THD_RESP_OKAY = 2'h0, THD_RESP_SLVERR = 2'h2} thd_resp_t;
endpackage : thd_pkg

/* File: hw/thd_dec24.sv */
// combinational 24/18 syndrome former and single-bit corrector for every bit but b12, whose error flips b8
`timescale 1ns/1ps
`include "thd_cfg.svh"
module thd_dec24 (
    // code word
    input  wire logic [23:0] codeWord,
    // decoded result
    output logic      [22:0] dataOut,
    output logic             invalid,
    output logic      [5:0]  checks,
    output logic      [4:0]  errPos
);
    // parity over a masked set of code bits
    function automatic logic parityOf(input logic [23:0] word, input logic [23:0] mask);
        parityOf = ^(word & mask);
    endfunction : parityOf

    logic [23:0] fixedWord;  // word after optional bit flip

    // ------------------------------------------------------------------------
    // checks and correction
    // ------------------------------------------------------------------------
    always_comb
    begin
        checks[0] = parityOf(codeWord, 24'h555555);
        checks[1] = parityOf(codeWord, 24'h666666);
        checks[2] = parityOf(codeWord, 24'h786878);
        checks[3] = parityOf(codeWord, 24'h007f80);
        checks[4] = parityOf(codeWord, 24'h7f8000);
        checks[5] = ^codeWord;
        // position from complemented first five checks
        errPos    = ~checks[4:0];
        fixedWord = codeWord;
        invalid   = 1'h0;
        if (&checks[4:0])
        begin
            // clean data bits, sixth check ignored
            invalid = 1'h0;
        end
        else if (!checks[5])
        begin
            // single error, position must be 1..23
            if (errPos == 5'h00 || errPos > `THD_LAST_POS)
                invalid = 1'h1;
            else
                fixedWord = codeWord ^ (24'h000001 << (errPos - 5'h01));
        end
        else
        begin
            invalid = 1'h1;
        end
        // layout kept in place, b23 replaced by the flag upstream
        dataOut = fixedWord[22:0];
    end
endmodule : thd_dec24

/* File: hw/thd_dec8.sv */
// combinational 8/4 checker returning b7 b5 b3 b1
`timescale 1ns/1ps
module thd_dec8 (
    // code byte
    input  wire logic [7:0] codeByte,
    // decoded result
    output logic      [3:0] nibble,
    output logic            invalid,
    output logic      [3:0] syndrome
);
    logic [7:0] b;  // short alias

    // ------------------------------------------------------------------------
    // syndrome and correction
    // ------------------------------------------------------------------------
    always_comb
    begin
        b           = codeByte;
        syndrome[3] = b[7] ^ b[5] ^ b[1] ^ b[0];
        syndrome[2] = b[7] ^ b[3] ^ b[2] ^ b[1];
        syndrome[1] = b[5] ^ b[4] ^ b[3] ^ b[1];
        syndrome[0] = ^b;
        nibble      = {b[7], b[5], b[3], b[1]};
        invalid     = 1'h0;
        // fix one data bit, accept protection errors
        case (syndrome)
            4'h0:    nibble[0] = ~b[1];
            4'h2:    nibble[3] = ~b[7];
            4'h4:    nibble[2] = ~b[5];
            4'h8:    nibble[1] = ~b[3];
            4'h6, 4'ha, 4'hc, 4'he, 4'hf: invalid = 1'h0;
            default: invalid = 1'h1;
        endcase
    end
endmodule : thd_dec8

/* File: hw/thd_top.sv */
// hamming decoding unit with axi4-lite register port
`timescale 1ns/1ps
`include "thd_cfg.svh"
module thd_top #(
    parameter int ADDR_W = 5  // byte address width
) (
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              rst,
    // write address channel
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    // write data channel
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    // write response channel
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    // read address channel
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    // read data channel
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    // interrupt
    output logic                   irq
);
    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    logic [ADDR_W-1:0] awAddr_ff;       // captured write address
    logic [31:0]       wData_ff;        // captured write data
    logic [3:0]        wStrb_ff;        // captured byte enables
    logic              awReady_ff;      // no write address held
    logic              wReady_ff;       // no write data held
    logic              bValid_ff;       // write response pending
    logic [1:0]        bResp_ff;        // write response code
    logic              arReady_ff;      // no read address held
    logic              rValid_ff;       // read data pending
    logic [31:0]       rData_ff;        // read data
    logic [1:0]        rResp_ff;        // read response code
    logic [7:0]        highByte_ff;     // hamming_input_high_byte
    logic [7:0]        midByte_ff;      // hamming_input_mid_byte
    logic [7:0]        lowByte_ff;      // hamming_input_low_byte
    logic              checkMode_ff;    // check_mode_select
    logic [23:0]       result_ff;       // decoded result with flag
    logic              lowWrPend_ff;    // last byte just written
    logic [1:0]        irqStatus_ff;    // sticky events
    logic [1:0]        irqMask_ff;      // event enables
    logic              irq_ff;          // interrupt line
    // ------------------------------------------------------------------------
    // combinational
    // ------------------------------------------------------------------------
    thd_pkg::thd_word_t codeWord;       // assembled code word
    logic [22:0]        data24;         // group decoder data
    logic               invalid24;      // group decoder flag
    logic [5:0]         checks24;       // group checks
    logic [4:0]         errPos24;       // group error position
    logic [3:0]         nibble8;        // byte decoder data
    logic               invalid8;       // byte decoder flag
    logic [3:0]         syndrome8;      // byte syndrome
    logic [23:0]        nxt_result;     // next result word
    logic               wrFire;         // write commits this cycle
    logic               wrHit;          // write address is mapped and writable
    logic               rdHit;          // read address is mapped
    logic [31:0]        rdWord;         // read mux output
    logic [1:0]         nxt_status;     // status after set and clear
    logic [1:0]         clearBits;      // write-one-to-clear bits
    // address decode shared by both directions
    function automatic logic isMapped(input logic [ADDR_W-1:0] addr);
        isMapped = (addr == `THD_OFF_HIGH)   || (addr == `THD_OFF_MID)  ||
                   (addr == `THD_OFF_LOW)    || (addr == `THD_OFF_CTRL) ||
                   (addr == `THD_OFF_RESULT) || (addr == `THD_OFF_STATUS) ||
                   (addr == `THD_OFF_MASK);
    endfunction : isMapped
    // byte registers form the word, b0 in the low byte
    assign codeWord = {highByte_ff, midByte_ff, lowByte_ff};
    // ------------------------------------------------------------------------
    // decoders
    // ------------------------------------------------------------------------
    thd_dec24 u_dec24 (
        .codeWord (codeWord),
        .dataOut  (data24),
        .invalid  (invalid24),
        .checks   (checks24),
        .errPos   (errPos24)
    );
    thd_dec8 u_dec8 (
        .codeByte (lowByte_ff),
        .nibble   (nibble8),
        .invalid  (invalid8),
        .syndrome (syndrome8)
    );
    // mode bit picks the check; flag placement
    always_comb
    begin
        nxt_result = 24'h000000;
        if (checkMode_ff == thd_pkg::THD_MODE_GROUP)
        begin
            nxt_result                 = {1'h0, data24};
            nxt_result[`THD_ERR24_BIT] = invalid24;
        end
        else
        begin
            nxt_result[3:0]           = nibble8;
            nxt_result[`THD_ERR8_BIT] = invalid8;
        end
    end
    // result follows the bytes one cycle later, no extra wait
    always_ff @(posedge mclk)
    begin
        if (rst)
            result_ff <= 24'h000000;
        else
            result_ff <= nxt_result;
    end

    // ------------------------------------------------------------------------
    // axi write path
    // ------------------------------------------------------------------------
    assign wrFire = !awReady_ff && !wReady_ff && !bValid_ff;
    assign wrHit  = isMapped(awAddr_ff) && (awAddr_ff != `THD_OFF_RESULT);
    // address and data captured independently, in either order;
    // the ready flops drive the ports directly, so no gate sits after them
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            awReady_ff <= 1'h1;
            wReady_ff  <= 1'h1;
            awAddr_ff  <= '0;
            wData_ff   <= 32'h00000000;
            wStrb_ff   <= 4'h0;
        end
        else
        begin
            if (awvalid && awReady_ff)
            begin
                awReady_ff <= 1'h0;
                awAddr_ff  <= awaddr;
            end
            else if (wrFire)
                awReady_ff <= 1'h1;
            if (wvalid && wReady_ff)
            begin
                wReady_ff <= 1'h0;
                wData_ff  <= wdata;
                wStrb_ff  <= wstrb;
            end
            else if (wrFire)
                wReady_ff <= 1'h1;
        end
    end
    // response once both halves were committed; result is read-only
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            bValid_ff <= 1'h0;
            bResp_ff  <= thd_pkg::THD_RESP_OKAY;
        end
        else if (wrFire)
        begin
            bValid_ff <= 1'h1;
            bResp_ff  <= wrHit ? thd_pkg::THD_RESP_OKAY : thd_pkg::THD_RESP_SLVERR;
        end
        else if (bready)
            bValid_ff <= 1'h0;
    end
    // byte and control registers, lane 0 only
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            highByte_ff  <= `THD_BYTE_RST;
            midByte_ff   <= `THD_BYTE_RST;
            lowByte_ff   <= `THD_BYTE_RST;
            checkMode_ff <= thd_pkg::THD_MODE_BYTE;
            irqMask_ff   <= `THD_FLAG_RST;
        end
        else if (wrFire && wStrb_ff[0])
        begin
            case (awAddr_ff)
                `THD_OFF_HIGH: highByte_ff  <= wData_ff[7:0];
                `THD_OFF_MID:  midByte_ff   <= wData_ff[7:0];
                `THD_OFF_LOW:  lowByte_ff   <= wData_ff[7:0];
                `THD_OFF_CTRL: checkMode_ff <= wData_ff[`THD_CTRL_MODE_BIT];
                `THD_OFF_MASK: irqMask_ff   <= wData_ff[1:0];
                default:       checkMode_ff <= checkMode_ff;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // events and interrupt
    // ------------------------------------------------------------------------
    // the low byte finishes a code word in either mode
    always_ff @(posedge mclk)
    begin
        if (rst)
            lowWrPend_ff <= 1'h0;
        else
            lowWrPend_ff <= wrFire && wStrb_ff[0] && (awAddr_ff == `THD_OFF_LOW);
    end

    // hardware set wins over a same-cycle software clear
    always_comb
    begin
        clearBits = 2'h0;
        if (wrFire && wStrb_ff[0] && awAddr_ff == `THD_OFF_STATUS)
            clearBits = wData_ff[1:0];
        nxt_status = irqStatus_ff & ~clearBits;
        if (lowWrPend_ff)
        begin
            nxt_status[`THD_STA_DONE_BIT] = 1'h1;
            // only the active check's flag counts: bit 4 is plain data in group mode
            if ((checkMode_ff == thd_pkg::THD_MODE_GROUP) ? invalid24 : invalid8)
                nxt_status[`THD_STA_ERR_BIT] = 1'h1;
        end
    end

    // sticky status and masked level interrupt
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            irqStatus_ff <= `THD_FLAG_RST;
            irq_ff       <= 1'h0;
        end
        else
        begin
            irqStatus_ff <= nxt_status;
            irq_ff       <= |(nxt_status & irqMask_ff);
        end
    end

    // ------------------------------------------------------------------------
    // axi read path
    // ------------------------------------------------------------------------
    assign rdHit = isMapped(araddr);

    // read mux; unmapped addresses return zero
    always_comb
    begin
        rdWord = 32'h00000000;
        case (araddr)
            `THD_OFF_HIGH:   rdWord[7:0]  = highByte_ff;
            `THD_OFF_MID:    rdWord[7:0]  = midByte_ff;
            `THD_OFF_LOW:    rdWord[7:0]  = lowByte_ff;
            `THD_OFF_CTRL:   rdWord[0]    = checkMode_ff;
            `THD_OFF_RESULT: rdWord[23:0] = result_ff;
            `THD_OFF_STATUS: rdWord[1:0]  = irqStatus_ff;
            `THD_OFF_MASK:   rdWord[1:0]  = irqMask_ff;
            default:         rdWord       = 32'h00000000;
        endcase
    end

    // one read at a time; arready drops while data waits
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            arReady_ff <= 1'h1;
            rValid_ff  <= 1'h0;
            rData_ff   <= 32'h00000000;
            rResp_ff   <= thd_pkg::THD_RESP_OKAY;
        end
        else if (arvalid && arReady_ff)
        begin
            arReady_ff <= 1'h0;
            rValid_ff  <= 1'h1;
            rData_ff   <= rdWord;
            rResp_ff   <= rdHit ? thd_pkg::THD_RESP_OKAY : thd_pkg::THD_RESP_SLVERR;
        end
        else if (rValid_ff && rready)
        begin
            rValid_ff  <= 1'h0;
            arReady_ff <= 1'h1;
        end
    end

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    assign awready = awReady_ff;
    assign wready  = wReady_ff;
    assign bvalid  = bValid_ff;
    assign bresp   = bResp_ff;
    assign arready = arReady_ff;
    assign rvalid  = rValid_ff;
    assign rdata   = rData_ff;
    assign rresp   = rResp_ff;
    assign irq     = irq_ff;

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    logic groupMode;   // group check active and stable
    logic byteMode;    // byte check active and stable
    assign groupMode = (checkMode_ff == thd_pkg::THD_MODE_GROUP) && !wrFire;
    assign byteMode  = (checkMode_ff == thd_pkg::THD_MODE_BYTE) && !wrFire;
    sequence s_lastByte;
        wrFire && wStrb_ff[0] && (awAddr_ff == `THD_OFF_LOW);
    endsequence
    sequence s_doneSeen;
        ##2 irqStatus_ff[`THD_STA_DONE_BIT];
    endsequence
    a_sixth_check: assert property (checks24[5] == ^codeWord)
        else $error("sixth check differs from full parity");
    a_pos_form: assert property (errPos24 == ~checks24[4:0])
        else $error("error position not complemented checks");
    a_clean_accept: assert property (groupMode && (&checks24[4:0]) |=>
        (result_ff == {1'h0, $past(codeWord[22:0])}))
        else $error("clean group altered or flagged");
    a_double_err: assert property (groupMode && !(&checks24[4:0]) && checks24[5] |=>
        result_ff[`THD_ERR24_BIT])
        else $error("double error not flagged");
    a_bad_pos: assert property (groupMode && !(&checks24[4:0]) && !checks24[5] &&
        (errPos24 == 5'h00 || errPos24 > `THD_LAST_POS) |=> result_ff[`THD_ERR24_BIT])
        else $error("out of range position not flagged");
    // single error corrected at its position
    a_single_fix: assert property (groupMode && !checks24[5] && errPos24 != 5'h00 &&
        errPos24 <= `THD_LAST_POS |=> !result_ff[`THD_ERR24_BIT] &&
        (result_ff[22:0] == $past(codeWord[22:0] ^ (23'h000001 << (errPos24 - 5'h01)))))
        else $error("single error not corrected");
    // clean byte (syndrome f) result keeps b7 b5 b3 b1, unflagged
    a_byte_clean: assert property (byteMode && syndrome8 == 4'hf |=>
        result_ff[4:0] == {1'h0, $past(lowByte_ff[7]), $past(lowByte_ff[5]),
        $past(lowByte_ff[3]), $past(lowByte_ff[1])})
        else $error("clean byte altered");
    a_byte_reject: assert property (byteMode && syndrome8[0] && syndrome8 != 4'hf |=>
        result_ff[`THD_ERR8_BIT] && result_ff[23:5] == 19'h00000)
        else $error("multi error byte not flagged");
    // last byte raises the done event two edges later
    a_done_event: assert property (s_lastByte |-> s_doneSeen)
        else $error("done event missing after last byte");
    // write response held until taken
    a_bresp_hold: assert property (bValid_ff && !bready |=> bValid_ff && $stable(bResp_ff))
        else $error("write response dropped early");
endmodule : thd_top

/* File: test/thd_top_tb_top.sv */
// self-checking testbench of the hamming decoder register block
`timescale 1ns/1ps
`include "thd_cfg.svh"
module thd_top_tb_top;
    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    typedef struct packed {logic mode; logic [23:0] word; logic [23:0] exp; logic [23:0] mask;} thd_row_t;
    logic        mclk, rst;            // clock and reset
    logic [4:0]  awaddr, araddr;       // addresses
    logic        awvalid, wvalid, bready, arvalid, rready;
    logic [31:0] wdata;                // write payload
    logic [3:0]  wstrb;                // byte enables
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0]  bresp, rresp;         // responses
    logic [31:0] rdata;                // read payload
    logic [1:0]  lastResp;             // response of the last access
    logic [31:0] rd;                   // data of the last read
    int          miscompares, totalChecks;
    // clean codeword 00808b, then single, boundary, b23-only, double and triple errors; byte cases after
    localparam thd_row_t ROWS [0:16] = '{
        '{1'b1, 24'h00808b, 24'h00808b, 24'hffffff}, '{1'b1, 24'h00808f, 24'h00808b, 24'hffffff},
        '{1'b1, 24'h40808b, 24'h00808b, 24'hffffff}, '{1'b1, 24'h80808b, 24'h00808b, 24'hffffff},
        '{1'b1, 24'h00809f, 24'h80809f, 24'hffffff}, '{1'b1, 24'h80408b, 24'h80408b, 24'hffffff},
        '{1'b0, 24'h000015, 24'h000000, 24'hffffff}, '{1'b0, 24'h000095, 24'h000000, 24'hffffff},
        '{1'b0, 24'h000035, 24'h000000, 24'hffffff}, '{1'b0, 24'h000014, 24'h000000, 24'hffffff},
        '{1'b0, 24'h000017, 24'h000000, 24'hffffff}, '{1'b0, 24'h00001d, 24'h000000, 24'hffffff},
        '{1'b0, 24'h000011, 24'h000000, 24'hffffff}, '{1'b0, 24'h000005, 24'h000000, 24'hffffff},
        '{1'b0, 24'h000055, 24'h000000, 24'hffffff}, '{1'b0, 24'h0000ff, 24'h00000e, 24'hffffff},
        '{1'b0, 24'h000016, 24'h000010, 24'h000010}};

    // ------------------------------------------------------------------
    // clock, device and watchdog
    // ------------------------------------------------------------------
    initial begin mclk = 1'b0; forever #5 mclk = ~mclk; end
    thd_top #(.ADDR_W(5)) i_dut (.mclk(mclk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .irq(irq));
    // the whole run needs under 2000 cycles, so 20000 means a hang
    initial
    begin
        repeat (20000) @(posedge mclk);
        miscompares++;
        finish_test();
    end

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // write: address and data offered together, each dropped when taken
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        awaddr <= a; wdata <= d; wstrb <= 4'hf; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        lastResp = bresp;
        bready <= 1'b0;
        @(posedge mclk);   // idle edge keeps strobes from being driven twice in one step
    endtask : wr
    task automatic rdr(input logic [4:0] a);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do
        begin
            @(posedge mclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd = rdata; lastResp = rresp;
        rready <= 1'b0;
        @(posedge mclk);
    endtask : rdr
    // load mode and bytes, low byte last as software must
    task automatic dec(input logic m, input logic [23:0] w);
        wr(`THD_OFF_CTRL, {31'h0, m});
        if (m) begin wr(`THD_OFF_HIGH, {24'h0, w[23:16]}); wr(`THD_OFF_MID, {24'h0, w[15:8]}); end
        wr(`THD_OFF_LOW, {24'h0, w[7:0]});
    endtask : dec
    task automatic finish_test();
        $display("checks %0d mismatches %0d", totalChecks, miscompares);
        if (miscompares == 0 && totalChecks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : finish_test

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        miscompares = 0; totalChecks = 0; rst = 1'b1;
        awaddr = 5'h00; araddr = 5'h00; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
        arvalid = 1'b0; rready = 1'b0; wdata = 32'h0; wstrb = 4'h0;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        // reset values of the writable registers
        foreach (ROWS[i]) if (i < 7) begin rdr(5'(i * 4) & 5'h1c); if (i != 4) chk(rd, 32'h0); end
        chk({31'h0, irq}, 32'h0);
        $display("test reset done");
        // table of group and byte decodes
        foreach (ROWS[i])
        begin
            dec(ROWS[i].mode, ROWS[i].word);
            rdr(`THD_OFF_RESULT);
            chk(rd & {8'hff, ROWS[i].mask}, {8'h0, ROWS[i].exp});
            chk({30'h0, lastResp}, 32'h0);
        end
        $display("test decode table done");
        // interrupt: done and invalid are pending from the table
        wr(`THD_OFF_MASK, 32'h1);
        chk({31'h0, irq}, 32'h1);
        rdr(`THD_OFF_STATUS);
        chk(rd, 32'h3);
        wr(`THD_OFF_STATUS, 32'h3);
        rdr(`THD_OFF_STATUS);
        chk({rd[30:0], irq}, 32'h0);
        wr(`THD_OFF_MASK, 32'h2);
        dec(1'b1, 24'h808092);
        chk({31'h0, irq}, 32'h0);
        dec(1'b1, 24'h00809f);
        chk({31'h0, irq}, 32'h1);
        wr(`THD_OFF_STATUS, 32'h2);
        rdr(`THD_OFF_STATUS);
        chk({rd[30:0], irq}, 32'h2);
        $display("test interrupt done");
        // refusals: unmapped read, write to the read-only result and to a hole
        rdr(5'h1c);
        chk(rd, 32'h0);
        chk({30'h0, lastResp}, 32'h2);
        wr(`THD_OFF_RESULT, 32'hff);
        chk({30'h0, lastResp}, 32'h2);
        wr(5'h1c, 32'h1);
        chk({30'h0, lastResp}, 32'h2);
        $display("test refusals done");
        // reset in mid-run clears the pending done flag and the mode
        rst <= 1'b1;
        @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rdr(`THD_OFF_STATUS);
        chk(rd, 32'h0);
        rdr(`THD_OFF_CTRL);
        chk(rd, 32'h0);
        $display("test mid-run reset done");
        finish_test();
    end
endmodule : thd_top_tb_top
